// File: clk_mon_pkg.sv
// Constants, field layouts and reset values for the clock monitor and select.
// Assumes every file of the block imports it whole.
package clk_mon_pkg;

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	localparam int ADDR_W = 2;
	localparam int DATA_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 2'h0;
	localparam logic [ADDR_W-1:0] ADDR_STAT = 2'h1;

	// Control register, bit 0 is ext_gen_on, bit 5 is mon_irq_en.
	typedef struct packed {
		logic mon_irq_en;
		logic clk_sel;
		logic mon_fault;
		logic mon_on;
		logic int_gen_on;
		logic ext_gen_on;
	} ctrl_s;

	// Status register, bit 0 is ext_stable, bit 3 is int_dead.
	typedef struct packed {
		logic int_dead;
		logic ext_dead;
		logic int_stable;
		logic ext_stable;
	} stat_s;

	localparam int CTRL_W = $bits(ctrl_s);
	localparam int STAT_W = $bits(stat_s);
	localparam logic [CTRL_W-1:0] CTRL_RST = 6'h02;

	// ----------------------------------------------------------------
	// Dividers and counts
	// ----------------------------------------------------------------
	localparam int DIV_W = 12;
	localparam int XTAL_STAB_CYCLES = 4096;
	localparam int EXT_STAB_CYCLES = 16;
	localparam logic [DIV_W-1:0] XTAL_STAB_LAST = 12'hFFF;
	localparam logic [DIV_W-1:0] EXT_STAB_LAST = 12'h00F;
	localparam int REF_SHORT_BIT = 1;
	localparam int REF_LONG_BIT = 11;
	localparam logic [1:0] MISS_LIMIT = 2'h2;

endpackage

// File: act_detect.sv
// Activity detector: watches one source clock against a slower reference.
// Assumes falling-edge pulses and reference levels are all on mclk.
`timescale 1ns/1ps

module act_detect
	import clk_mon_pkg::*;
(
	// Clock and control
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	// Watched clock and reference
	input wire logic mon_fall,
	input wire logic ref_level,
	input wire logic ref_rise,
	// Result
	output logic dead
);

	logic seen_ff;
	logic nxt_seen;
	logic [1:0] miss_ff;
	logic [1:0] nxt_miss;
	logic dead_ff;
	logic nxt_dead;

	always_comb begin
		nxt_seen = seen_ff;
		nxt_miss = miss_ff;
		nxt_dead = dead_ff;
		if (!ref_level && mon_fall) begin
			nxt_seen = 1'b1;
			nxt_dead = 1'b0;
		end
		if (ref_rise) begin
			nxt_seen = 1'b0;
			if (seen_ff) begin
				nxt_miss = 2'h0;
			end else if (miss_ff == MISS_LIMIT - 2'h1) begin
				nxt_dead = 1'b1;
			end else begin
				nxt_miss = miss_ff + 2'h1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			seen_ff <= 1'b0;
			miss_ff <= 2'h0;
			dead_ff <= 1'b0;
		end else if (ce) begin
			seen_ff <= nxt_seen;
			miss_ff <= nxt_miss;
			dead_ff <= nxt_dead;
		end
	end

	assign dead = dead_ff;

endmodule

// File: clk_switch.sv
// Glitch-free two-way clock switch between internal and external sources.
// Assumes source levels and their falling-edge pulses are on mclk.
`timescale 1ns/1ps

module clk_switch
	import clk_mon_pkg::*;
(
	// Clock and control
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	// Selection
	input wire logic sel_ext,
	input wire logic kill_int,
	input wire logic kill_ext,
	// Sources
	input wire logic int_lvl,
	input wire logic int_fall,
	input wire logic ext_lvl,
	input wire logic ext_fall,
	// Switched clock
	output logic clk_out
);

	logic int_s1_ff, int_s2_ff, ext_s1_ff, ext_s2_ff, out_ff;
	logic nxt_int_s1, nxt_int_s2, nxt_ext_s1, nxt_ext_s2, nxt_out;

	// Each side steps only on its own falling edge, so the output can
	// only open or close while that source is low.
	always_comb begin
		nxt_int_s1 = int_s1_ff;
		nxt_int_s2 = int_s2_ff;
		nxt_ext_s1 = ext_s1_ff;
		nxt_ext_s2 = ext_s2_ff;
		if (int_fall) begin
			nxt_int_s1 = !sel_ext && !ext_s2_ff;
			nxt_int_s2 = int_s1_ff;
		end
		if (ext_fall) begin
			nxt_ext_s1 = sel_ext && !int_s2_ff;
			nxt_ext_s2 = ext_s1_ff;
		end
		// A dead side has no edges to step on, so it is cleared outright.
		if (kill_int) begin
			nxt_int_s1 = 1'b0;
			nxt_int_s2 = 1'b0;
		end
		if (kill_ext) begin
			nxt_ext_s1 = 1'b0;
			nxt_ext_s2 = 1'b0;
		end
		nxt_out = (int_lvl && int_s2_ff) || (ext_lvl && ext_s2_ff);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			int_s1_ff <= 1'b1;
			int_s2_ff <= 1'b1;
			ext_s1_ff <= 1'b0;
			ext_s2_ff <= 1'b0;
			out_ff <= 1'b0;
		end else if (ce) begin
			int_s1_ff <= nxt_int_s1;
			int_s2_ff <= nxt_int_s2;
			ext_s1_ff <= nxt_ext_s1;
			ext_s2_ff <= nxt_ext_s2;
			out_ff <= nxt_out;
		end
	end

	assign clk_out = out_ff;

endmodule

// File: clock_monitor_and_select.sv
// Clock monitor and clock selection: activity detection, external stability,
// glitch-free source switching and the divided bus source clock.
// Assumes all source clocks are sampled levels synchronous to mclk.
`timescale 1ns/1ps

// What this block does
// - External clock dead after two reference low phases with no falling edge.
// - External dead flag clears at first external fall while reference low.
// - External stable sets after 4096 cycles in crystal mode, else 16.
// - External stable clears when generator disabled or external clock dead.
// - Oscillator output follows external clock when select is one, else internal.
// - A written select takes effect only with both generators on and target stable.
// - Timebase clock follows external while external generator on, except when forced to internal.
// - Bus source clock is oscillator output divided by two.
// - Switch keeps the old clock one to two cycles after select change.
// - Switch output held low one to two new-clock cycles, then runs.
// - Reset selects the internal clock in both switches.
// - Monitor on plus dead flag forces the live clock, kills dead side.
// - Forced selection takes one to two cycles after the dead flag.
// - Monitor on bit stays set when a clock later goes unstable.
// - Fault flag clears on read seeing it then writing zero.
// - On inactivity with monitor on, both outputs move to live source; select shows it.
// - Internal dead after two external reference low phases with no low-frequency base clock fall.
module clock_monitor_and_select
	import clk_mon_pkg::*;
(
	// Clock, reset and clock enable
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	// Register port
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [DATA_W-1:0] rd_data,
	// Source clocks
	input wire logic internal_clock,
	input wire logic external_clock,
	input wire logic low_freq_base_clock,
	// Configuration and status from outside
	input wire logic crystal_mode_cfg,
	input wire logic slow_crystal_cfg,
	input wire logic stop_mode,
	input wire logic int_filter_stable,
	// Generated clocks and request
	output logic osc_out_clock,
	output logic timebase_clock,
	output logic bus_source_clock,
	output logic mon_irq
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic internal_clock_prev_ff, external_clock_prev_ff, base_prev_ff;
	logic [DIV_W-1:0] ext_div_ff, nxt_ext_div;
	logic [DIV_W-1:0] base_div_ff, nxt_base_div;
	logic ext_stable_ff, nxt_ext_stable;
	logic internal_reference_ff, nxt_internal_reference, internal_reference_d_ff;
	logic external_reference_ff, nxt_external_reference, external_reference_d_ff;
	ctrl_s ctrl_ff, nxt_ctrl;
	logic clr_arm_ff, nxt_clr_arm;
	logic dead_prev_ff;
	logic [DATA_W-1:0] rd_data_ff, nxt_rd_data;
	logic mon_irq_ff, nxt_mon_irq;
	logic bus_src_ff, nxt_bus_src;
	logic osc_prev_ff;

	logic internal_clock_fall, external_clock_fall, base_fall;
	logic ext_gen_enable_sig;
	logic ext_clk_dead_flag, int_clk_dead_flag;
	logic int_clk_stable;
	logic force_int, force_ext;
	logic osc_sel_ext, tb_sel_ext;
	logic osc_sw, tb_sw;
	stat_s stat;
	ctrl_s wr_ctrl;
	logic both_on, target_ok, mon_ok;
	logic internal_reference_rise, external_reference_rise;

	assign internal_clock_fall = internal_clock_prev_ff && !internal_clock;
	assign external_clock_fall = external_clock_prev_ff && !external_clock;
	assign base_fall = base_prev_ff && !low_freq_base_clock;
	assign ext_gen_enable_sig = ctrl_ff.ext_gen_on && !stop_mode;
	assign int_clk_stable = int_filter_stable && ctrl_ff.int_gen_on &&
		!int_clk_dead_flag;

	// A dead clock is only acted on while the monitor is on.
	assign force_int = ctrl_ff.mon_on && ext_clk_dead_flag;
	assign force_ext = ctrl_ff.mon_on && int_clk_dead_flag && !force_int;
	assign osc_sel_ext = force_ext || (ctrl_ff.clk_sel && !force_int);
	assign tb_sel_ext = force_ext || (ctrl_ff.ext_gen_on && !force_int);
	// The survivor's synchroniser still steps only on its own falling
	// edges, so a forced selection lands one to two of its cycles later.

	assign stat.int_dead = int_clk_dead_flag;
	assign stat.ext_dead = ext_clk_dead_flag;
	assign stat.int_stable = int_clk_stable;
	assign stat.ext_stable = ext_stable_ff;

	// ----------------------------------------------------------------
	// Activity detectors and clock switches
	// ----------------------------------------------------------------
	// Both detectors judge a low phase at the rise that ends it.
	assign internal_reference_rise = internal_reference_ff && !internal_reference_d_ff;
	assign external_reference_rise = external_reference_ff && !external_reference_d_ff;

	act_detect u_ext_det (
		.mclk(mclk),
		.rst_n(rst_n),
		.ce(ce),
		.mon_fall(external_clock_fall),
		.ref_level(internal_reference_ff),
		.ref_rise(internal_reference_rise),
		.dead(ext_clk_dead_flag)
	);

	act_detect u_int_det (
		.mclk(mclk),
		.rst_n(rst_n),
		.ce(ce),
		.mon_fall(base_fall),
		.ref_level(external_reference_ff),
		.ref_rise(external_reference_rise),
		.dead(int_clk_dead_flag)
	);

	clk_switch u_osc_sw (
		.mclk(mclk),
		.rst_n(rst_n),
		.ce(ce),
		.sel_ext(osc_sel_ext),
		.kill_int(force_ext),
		.kill_ext(force_int),
		.int_lvl(internal_clock),
		.int_fall(internal_clock_fall),
		.ext_lvl(external_clock),
		.ext_fall(external_clock_fall),
		.clk_out(osc_sw)
	);

	clk_switch u_tb_sw (
		.mclk(mclk),
		.rst_n(rst_n),
		.ce(ce),
		.sel_ext(tb_sel_ext),
		.kill_int(force_ext),
		.kill_ext(force_int),
		.int_lvl(internal_clock),
		.int_fall(internal_clock_fall),
		.ext_lvl(external_clock),
		.ext_fall(external_clock_fall),
		.clk_out(tb_sw)
	);

	// ----------------------------------------------------------------
	// Dividers, references and stabilization
	// ----------------------------------------------------------------
	// The long divider doubles as the stabilization counter, so it is held
	// in reset while the external generator is off.
	always_comb begin
		nxt_ext_div = ext_div_ff;
		nxt_base_div = base_div_ff;
		nxt_ext_stable = ext_stable_ff;
		if (!ext_gen_enable_sig) begin
			nxt_ext_div = '0;
		end else if (external_clock_fall) begin
			nxt_ext_div = ext_div_ff + 12'h001;
			if (ext_div_ff == (crystal_mode_cfg ? XTAL_STAB_LAST :
				EXT_STAB_LAST)) begin
				nxt_ext_stable = 1'b1;
			end
		end
		if (base_fall) begin
			nxt_base_div = base_div_ff + 12'h001;
		end
		if (!ext_gen_enable_sig || ext_clk_dead_flag) begin
			nxt_ext_stable = 1'b0;
		end
		// The slow side uses the short divider, the fast side the long one.
		nxt_internal_reference = slow_crystal_cfg ? base_div_ff[REF_LONG_BIT] :
			base_div_ff[REF_SHORT_BIT];
		nxt_external_reference = slow_crystal_cfg ? ext_div_ff[REF_SHORT_BIT] :
			ext_div_ff[REF_LONG_BIT];
	end

	// ----------------------------------------------------------------
	// Registers and derived outputs
	// ----------------------------------------------------------------
	always_comb begin
		wr_ctrl = ctrl_s'(wr_data[CTRL_W-1:0]);
		both_on = ctrl_ff.int_gen_on && ctrl_ff.ext_gen_on;
		target_ok = wr_ctrl.clk_sel ? ext_stable_ff : int_clk_stable;
		mon_ok = both_on && ext_stable_ff && int_clk_stable;
		nxt_ctrl = ctrl_ff;
		nxt_clr_arm = clr_arm_ff;
		nxt_rd_data = '0;
		if (wr_stb && addr == ADDR_CTRL) begin
			nxt_ctrl.ext_gen_on = wr_ctrl.ext_gen_on;
			nxt_ctrl.int_gen_on = wr_ctrl.int_gen_on;
			nxt_ctrl.mon_irq_en = wr_ctrl.mon_irq_en;
			// Once on, the monitor stays on until software writes zero.
			if (!wr_ctrl.mon_on) begin
				nxt_ctrl.mon_on = 1'b0;
			end else if (mon_ok) begin
				nxt_ctrl.mon_on = 1'b1;
			end
			if (both_on && target_ok) begin
				nxt_ctrl.clk_sel = wr_ctrl.clk_sel;
			end
			if (!wr_ctrl.mon_fault && clr_arm_ff) begin
				nxt_ctrl.mon_fault = 1'b0;
				nxt_clr_arm = 1'b0;
			end
		end
		if (rd_stb) begin
			unique case (addr)
				ADDR_CTRL: begin
					nxt_rd_data = DATA_W'(ctrl_ff);
					if (ctrl_ff.mon_fault) begin
						nxt_clr_arm = 1'b1;
					end
				end
				ADDR_STAT: nxt_rd_data = DATA_W'(stat);
				default: nxt_rd_data = '0;
			endcase
		end
		// The select bit follows a forced switch so software sees the survivor.
		if (force_int) begin
			nxt_ctrl.clk_sel = 1'b0;
		end else if (force_ext) begin
			nxt_ctrl.clk_sel = 1'b1;
		end
		// A new dead event beats a clear in the same cycle.
		if (ctrl_ff.mon_on && (ext_clk_dead_flag || int_clk_dead_flag) &&
			!dead_prev_ff) begin
			nxt_ctrl.mon_fault = 1'b1;
			nxt_clr_arm = 1'b0;
		end
		nxt_mon_irq = nxt_ctrl.mon_fault && nxt_ctrl.mon_irq_en;
		nxt_bus_src = bus_src_ff;
		if (osc_prev_ff && !osc_sw) begin
			nxt_bus_src = !bus_src_ff;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			internal_clock_prev_ff <= 1'b0;
			external_clock_prev_ff <= 1'b0;
			base_prev_ff <= 1'b0;
			ext_div_ff <= '0;
			base_div_ff <= '0;
			ext_stable_ff <= 1'b0;
			internal_reference_ff <= 1'b0;
			internal_reference_d_ff <= 1'b0;
			external_reference_ff <= 1'b0;
			external_reference_d_ff <= 1'b0;
			ctrl_ff <= ctrl_s'(CTRL_RST);
			clr_arm_ff <= 1'b0;
			dead_prev_ff <= 1'b0;
			rd_data_ff <= '0;
			mon_irq_ff <= 1'b0;
			bus_src_ff <= 1'b0;
			osc_prev_ff <= 1'b0;
		end else if (ce) begin
			internal_clock_prev_ff <= internal_clock;
			external_clock_prev_ff <= external_clock;
			base_prev_ff <= low_freq_base_clock;
			ext_div_ff <= nxt_ext_div;
			base_div_ff <= nxt_base_div;
			ext_stable_ff <= nxt_ext_stable;
			internal_reference_ff <= nxt_internal_reference;
			internal_reference_d_ff <= internal_reference_ff;
			external_reference_ff <= nxt_external_reference;
			external_reference_d_ff <= external_reference_ff;
			ctrl_ff <= nxt_ctrl;
			clr_arm_ff <= nxt_clr_arm;
			dead_prev_ff <= ext_clk_dead_flag || int_clk_dead_flag;
			rd_data_ff <= nxt_rd_data;
			mon_irq_ff <= nxt_mon_irq;
			bus_src_ff <= nxt_bus_src;
			osc_prev_ff <= osc_sw;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Every output is a flop, so nothing downstream sees a comb glitch.
	assign rd_data = rd_data_ff;
	assign osc_out_clock = osc_sw;
	assign timebase_clock = tb_sw;
	assign bus_source_clock = bus_src_ff;
	assign mon_irq = mon_irq_ff;

endmodule

// File: clk_mon_monitor.sv
// Port checker for the clock monitor and select block.
// Assumes ce is held high and sources are levels sampled on mclk.
`timescale 1ns/1ps

module clk_mon_monitor
	import clk_mon_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Sources and generated clocks
	input wire logic internal_clock,
	input wire logic external_clock,
	input wire logic osc_out_clock,
	input wire logic timebase_clock,
	input wire logic bus_source_clock
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_reset_int_sel: assert property ($past(rst_n) && !$past(rst_n, 2) |->
		osc_out_clock == $past(internal_clock) &&
		timebase_clock == $past(internal_clock))
		else $error("switch not on internal clock after reset");
	a_osc_from_src: assert property (osc_out_clock |->
		$past(internal_clock) || $past(external_clock))
		else $error("oscillator output high with both sources low");
	a_tb_from_src: assert property (timebase_clock |->
		$past(internal_clock) || $past(external_clock))
		else $error("timebase high with both sources low");
	a_osc_no_runt: assert property ($rose(osc_out_clock) |=>
		osc_out_clock)
		else $error("oscillator output high pulse too short");
	a_osc_low_held: assert property ($fell(osc_out_clock) |=>
		!osc_out_clock)
		else $error("oscillator output low pulse too short");
	a_tb_no_runt: assert property ($rose(timebase_clock) |=>
		timebase_clock)
		else $error("timebase high pulse too short");
	a_bus_on_fall: assert property ($fell(osc_out_clock) |->
		##[0:1] $changed(bus_source_clock))
		else $error("bus clock missed an oscillator fall");
	a_bus_at_low: assert property ($changed(bus_source_clock) |->
		!osc_out_clock)
		else $error("bus clock moved while oscillator high");
endmodule

bind clock_monitor_and_select clk_mon_monitor u_mon (
	.mclk(mclk),
	.rst_n(rst_n),
	.internal_clock(internal_clock),
	.external_clock(external_clock),
	.osc_out_clock(osc_out_clock),
	.timebase_clock(timebase_clock),
	.bus_source_clock(bus_source_clock)
);

// File: ext_osc.sv
// External crystal model: a clock of four mclk periods that can die.
// Assumes the block samples its level on mclk.
`timescale 1ns/1ps

module ext_osc (
	// Clock
	input wire logic mclk,
	// Control
	input wire logic run,
	// Crystal output
	output logic external_clock
);
	logic [1:0] ph_ff = 2'h1;

	// A dead crystal holds its last level, the hardest case to spot.
	always @(posedge mclk) begin
		if (run) begin
			ph_ff <= ph_ff + 2'h1;
		end
	end
	assign external_clock = ph_ff[1];
endmodule

// File: tb_clock_monitor_and_select.sv
// Testbench for the clock monitor and select block.
// Assumes the crystal model and the bound checker are compiled with it.
`timescale 1ns/1ps

module tb_clock_monitor_and_select
	import clk_mon_pkg::*;
;
	logic mclk, rst_n, wr_stb, rd_stb, crystal_mode_cfg, stop_mode, run;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wr_data, rd_data;
	logic internal_clock, external_clock, int_d, ext_d, mon_irq;
	logic osc_out_clock, timebase_clock, bus_source_clock;
	logic [1:0] ph = 2'h0;
	int n_mismatch = 0;
	int tests_run = 0;

	clock_monitor_and_select dut (.mclk(mclk), .rst_n(rst_n), .ce(1'b1),
		.addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
		.rd_data(rd_data), .internal_clock(internal_clock),
		.external_clock(external_clock), .low_freq_base_clock(ph[1]),
		.crystal_mode_cfg(crystal_mode_cfg), .slow_crystal_cfg(1'b0),
		.stop_mode(stop_mode), .int_filter_stable(1'b1),
		.osc_out_clock(osc_out_clock), .timebase_clock(timebase_clock),
		.bus_source_clock(bus_source_clock), .mon_irq(mon_irq));
	ext_osc xtal (.mclk(mclk), .run(run), .external_clock(external_clock));

	assign internal_clock = ph[1];
	always @(posedge mclk) begin
		ph <= ph + 2'h1;
		int_d <= internal_clock;
		ext_d <= external_clock;
	end
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic close_out();
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wr_data <= d;
		wr_stb <= 1'b1;
		@(posedge mclk);
		wr_stb <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge mclk);
		rd_stb <= 1'b0;
		#1;
		d = rd_data;
	endtask
	task automatic rdc(input logic [1:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk(d, e);
	endtask
	// Polls status until the masked bits match; n counts mclk cycles.
	task automatic wait_st(input logic [7:0] m, input int lim, output int n);
		logic [7:0] d;
		n = 0;
		rd(ADDR_STAT, d);
		while ((d & m) !== m && n < lim) begin
			rd(ADDR_STAT, d);
			n += 2;
		end
	endtask
	// Eight cycles span two source periods, so the bus clock moves twice.
	task automatic follow(input logic oe, input logic te);
		int nb;
		logic pb;
		nb = 0;
		repeat (20) @(posedge mclk);
		#1;
		pb = bus_source_clock;
		repeat (8) begin
			@(posedge mclk);
			#1;
			chk({7'h00, osc_out_clock}, {7'h00, oe ? ext_d : int_d});
			chk({7'h00, timebase_clock}, {7'h00, te ? ext_d : int_d});
			if (bus_source_clock !== pb) begin
				nb++;
			end
			pb = bus_source_clock;
		end
		chk(8'(nb), 8'h02);
	endtask

	task automatic t_reset();
		rdc(ADDR_CTRL, 8'h02);
		rdc(ADDR_STAT, 8'h02);
		rdc(2'h2, 8'h00);
		rdc(2'h3, 8'h00);
	endtask
	task automatic t_stab(input logic mode, input int f);
		int n;
		@(posedge mclk);
		crystal_mode_cfg <= mode;
		wr(ADDR_CTRL, 8'h02);
		repeat (4) @(posedge mclk);
		wr(ADDR_CTRL, 8'h03);
		wr(ADDR_CTRL, 8'h13);
		rdc(ADDR_CTRL, 8'h03);
		wait_st(8'h01, 5 * f, n);
		chk({7'h00, n > 4 * f - 16 && n < 4 * f + 8}, 8'h01);
	endtask
	task automatic t_stop();
		int n;
		@(posedge mclk);
		stop_mode <= 1'b1;
		repeat (3) @(posedge mclk);
		rdc(ADDR_STAT, 8'h02);
		@(posedge mclk);
		stop_mode <= 1'b0;
		wait_st(8'h01, 80, n);
		chk({7'h00, n > 48 && n < 72}, 8'h01);
	endtask
	task automatic t_switch();
		wr(ADDR_CTRL, 8'h13);
		rdc(ADDR_CTRL, 8'h13);
		follow(1'b1, 1'b1);
		wr(ADDR_CTRL, 8'h02);
		rdc(ADDR_CTRL, 8'h02);
		follow(1'b0, 1'b0);
	endtask
	task automatic t_monitor();
		int n;
		wr(ADDR_CTRL, 8'h13);
		wr(ADDR_CTRL, 8'h17);
		wr(ADDR_CTRL, 8'h37);
		rdc(ADDR_CTRL, 8'h37);
		@(posedge mclk);
		run <= 1'b0;
		n = 0;
		while (mon_irq !== 1'b1 && n < 200) begin
			@(posedge mclk);
			n++;
		end
		chk({7'h00, mon_irq}, 8'h01);
		wr(ADDR_CTRL, 8'h27);
		rdc(ADDR_STAT, 8'h06);
		rdc(ADDR_CTRL, 8'h2F);
		follow(1'b0, 1'b0);
		wr(ADDR_CTRL, 8'h2F);
		rdc(ADDR_CTRL, 8'h2F);
		wr(ADDR_CTRL, 8'h27);
		rdc(ADDR_CTRL, 8'h27);
		chk({7'h00, mon_irq}, 8'h00);
		wr(ADDR_CTRL, 8'h23);
		run <= 1'b1;
		repeat (40) @(posedge mclk);
		rdc(ADDR_STAT & 2'h1, 8'h02);
	endtask

	initial begin
		rst_n = 1'b0;
		addr = '0;
		wr_data = '0;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		crystal_mode_cfg = 1'b0;
		stop_mode = 1'b0;
		run = 1'b1;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		t_reset();
		t_stab(1'b1, 4096);
		t_stab(1'b0, 16);
		t_stop();
		t_switch();
		t_stab(1'b0, 16);
		t_monitor();
		close_out();
	end
	// Longest path is the 4096-fall crystal wait, about 17000 cycles.
	initial begin
		#400000;
		n_mismatch++;
		close_out();
	end
endmodule
